/* logic/prf_chain.sv */
// Lookup and register chains inside one cluster
`timescale 1ns/100ps
module prf_chain
  import prf_pkg::*;
#(
  parameter int CELLS = PRF_CELLS
) (
  input wire logic en_i,
  input wire logic [CELLS-1:0] comb_i,
  input wire logic [CELLS-1:0] regq_i,
  output logic [CELLS-1:0] fast_o,
  output logic [CELLS-1:0] regd_o
);

  // ==========================================================
  // Chains: first cell has no upstream neighbour
  always_comb begin
    fast_o = '0;
    regd_o = '0;
    for (int i = 1; i < CELLS; i++) begin
      fast_o[i] = en_i & comb_i[i-1];
      regd_o[i] = en_i & regq_i[i-1];
    end
  end

endmodule

/* logic/prf_fabric.sv */
// Programmable routing fabric of a logic array
`timescale 1ns/100ps
module prf_fabric
  import prf_pkg::*;
#(
  parameter int NR = PRF_ROWS,
  parameter int NC = PRF_COLS,
  parameter int CELLS = PRF_CELLS,
  parameter int RW = $clog2(PRF_ROWS),
  parameter int CW = $clog2(PRF_COLS)
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic cfg_we_i,
  input wire logic [RW-1:0] cfg_row_i,
  input wire logic [CW-1:0] cfg_col_i,
  input wire logic [PRF_CFG_W-1:0] cfg_word_i,
  input wire logic [NR-1:0][NC-1:0] blk_out_i,
  input wire logic [NR-1:0][PRF_CLK_LINES-1:0] row_clk_i,
  input wire logic [NR-1:0][NC-1:0][CELLS-1:0] cell_comb_i,
  input wire logic [NR-1:0][NC-1:0][CELLS-1:0] cell_regq_i,
  output logic run_o,
  output logic [NR-1:0][NC-1:0] loc_o,
  output logic [NR-1:0][NC-1:0] blk_clk_o,
  output logic [NR-1:0][NC-1:0][CELLS-1:0] fast_in_o,
  output logic [NR-1:0][NC-1:0][CELLS-1:0] reg_in_o
);

  localparam int NSR = (NC + PRF_ROW_LONG_SPAN - 1) / PRF_ROW_LONG_SPAN;
  localparam int NSC = (NR + PRF_COL_LONG_SPAN - 1) / PRF_COL_LONG_SPAN;

  // ==========================================================
  // Configuration store
  prf_cfg_s cfg_r [NR][NC];
  logic run_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run_r <= PRF_RUN_RST;
    end else begin
      run_r <= run_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int r = 0; r < NR; r++) begin
        for (int c = 0; c < NC; c++) begin
          cfg_r[r][c] <= PRF_CFG_RST;
        end
      end
    end else if (cfg_we_i && !run_r && int'(cfg_row_i) < NR &&
                 int'(cfg_col_i) < NC) begin
      cfg_r[cfg_row_i][cfg_col_i] <= prf_cfg_s'(cfg_word_i);
    end
  end

  assign run_o = run_r;

  // ==========================================================
  // Helpers
  function automatic logic bit_at(input logic [NR-1:0][NC-1:0] m,
                                  input int r, input int c);
    bit_at = 1'b0;
    if (r >= 0 && r < NR && c >= 0 && c < NC) begin
      bit_at = m[r][c];
    end
  endfunction

  function automatic logic pick(input prf_src_e s, input logic a,
                                input logic b, input logic x,
                                input logic d);
    unique case (s)
      PRF_SRC_BLOCK: pick = a;
      PRF_SRC_SAME: pick = b;
      PRF_SRC_CROSS: pick = x;
      PRF_SRC_LONG: pick = d;
    endcase
  endfunction

  // ==========================================================
  // Direction and kind masks
  logic [NR-1:0][NC-1:0] big_m;
  logic [NR-1:0][NC-1:0] r4_rt_m;
  logic [NR-1:0][NC-1:0] r8_rt_m;
  logic [NR-1:0][NC-1:0] c4_up_m;
  logic [NR-1:0][NC-1:0] c8_up_m;

  always_comb begin
    for (int r = 0; r < NR; r++) begin
      for (int c = 0; c < NC; c++) begin
        big_m[r][c] = cfg_r[r][c].kind == PRF_BIG_RAM;
        r4_rt_m[r][c] = cfg_r[r][c].r4_fwd;
        r8_rt_m[r][c] = cfg_r[r][c].r8_fwd;
        c4_up_m[r][c] = cfg_r[r][c].c4_fwd;
        c8_up_m[r][c] = cfg_r[r][c].c8_fwd;
      end
    end
  end

  // ==========================================================
  // Wire values and arrivals
  logic [NR-1:0][NC-1:0] r4_w;
  logic [NR-1:0][NC-1:0] r8_w;
  logic [NR-1:0][NC-1:0] c4_w;
  logic [NR-1:0][NC-1:0] c8_w;
  logic [NR-1:0][NC-1:0] r4_arr;
  logic [NR-1:0][NC-1:0] r8_arr;
  logic [NR-1:0][NC-1:0] c4_arr;
  logic [NR-1:0][NC-1:0] c8_arr;
  logic [NR-1:0][NSR-1:0] rl_w;
  logic [NSC-1:0][NC-1:0] cl_w;

  // Arrivals at the far end of each span; a large RAM hears row wires only from its left
  always_comb begin
    for (int r = 0; r < NR; r++) begin
      for (int c = 0; c < NC; c++) begin
        r4_arr[r][c] =
          (bit_at(r4_rt_m, r, c - PRF_FOUR_SPAN) &
           bit_at(r4_w, r, c - PRF_FOUR_SPAN)) |
          (~big_m[r][c] & ~bit_at(r4_rt_m, r, c + PRF_FOUR_SPAN) &
           bit_at(r4_w, r, c + PRF_FOUR_SPAN));
        r8_arr[r][c] =
          (bit_at(r8_rt_m, r, c - PRF_EIGHT_SPAN) &
           bit_at(r8_w, r, c - PRF_EIGHT_SPAN)) |
          (~big_m[r][c] & ~bit_at(r8_rt_m, r, c + PRF_EIGHT_SPAN) &
           bit_at(r8_w, r, c + PRF_EIGHT_SPAN));
        c4_arr[r][c] =
          (bit_at(c4_up_m, r + PRF_FOUR_SPAN, c) &
           bit_at(c4_w, r + PRF_FOUR_SPAN, c)) |
          (~bit_at(c4_up_m, r - PRF_FOUR_SPAN, c) &
           bit_at(c4_w, r - PRF_FOUR_SPAN, c));
        c8_arr[r][c] =
          (bit_at(c8_up_m, r + PRF_EIGHT_SPAN, c) &
           bit_at(c8_w, r + PRF_EIGHT_SPAN, c)) |
          (~bit_at(c8_up_m, r - PRF_EIGHT_SPAN, c) &
           bit_at(c8_w, r - PRF_EIGHT_SPAN, c));
      end
    end
  end

  // ==========================================================
  // Row and column span wires
  always_comb begin
    prf_cfg_s k;
    logic drv;
    logic lng;
    logic rl_tap;
    logic cl_tap;
    k = PRF_CFG_RST;
    drv = 1'b0;
    lng = 1'b0;
    rl_tap = 1'b0;
    cl_tap = 1'b0;
    for (int r = 0; r < NR; r++) begin
      for (int c = 0; c < NC; c++) begin
        k = cfg_r[r][c];
        rl_tap = (c % PRF_TAP_STEP) == 0;
        cl_tap = (r % PRF_TAP_STEP) == 0;
        // Row four-wire, driven by primary or its neighbour
        if (k.r4_nbr) begin
          drv = k.r4_fwd ? bit_at(blk_out_i, r, c + 1) :
                           bit_at(blk_out_i, r, c - 1);
        end else begin
          drv = blk_out_i[r][c];
        end
        if ((big_m[r][c] && k.r4_fwd) ||
            (k.r4_nbr && !k.r4_fwd && bit_at(big_m, r, c - 1))) begin
          drv = 1'b0;
        end
        lng = rl_tap ? rl_w[r][c / PRF_ROW_LONG_SPAN] : 1'b0;
        r4_w[r][c] = k.r4_en & ~(big_m[r][c] & k.r4_fwd) &
          pick(k.r4_src, drv, r4_arr[r][c], c4_arr[r][c], lng);
        // Row eight-wire
        if (k.r8_nbr) begin
          drv = k.r8_fwd ? bit_at(blk_out_i, r, c + 1) :
                           bit_at(blk_out_i, r, c - 1);
        end else begin
          drv = blk_out_i[r][c];
        end
        if ((big_m[r][c] && k.r8_fwd) ||
            (k.r8_nbr && !k.r8_fwd && bit_at(big_m, r, c - 1))) begin
          drv = 1'b0;
        end
        r8_w[r][c] = k.r8_en & ~(big_m[r][c] & k.r8_fwd) &
          pick(k.r8_src, drv, r8_arr[r][c], c8_arr[r][c], 1'b0);
        // Column four-wire
        if (k.c4_nbr) begin
          drv = bit_at(blk_out_i, r, c + 1);
        end else begin
          drv = blk_out_i[r][c];
        end
        lng = (cl_tap ? cl_w[r / PRF_COL_LONG_SPAN][c] : 1'b0) |
              (rl_tap ? rl_w[r][c / PRF_ROW_LONG_SPAN] : 1'b0);
        c4_w[r][c] = k.c4_en &
          pick(k.c4_src, drv, c4_arr[r][c], r4_arr[r][c], lng);
        // Column eight-wire
        if (k.c8_nbr) begin
          drv = bit_at(blk_out_i, r, c + 1);
        end else begin
          drv = blk_out_i[r][c];
        end
        c8_w[r][c] = k.c8_en &
          pick(k.c8_src, drv, c8_arr[r][c], r8_arr[r][c], 1'b0);
      end
    end
  end

  // ==========================================================
  // Long wires, tapped at every fourth position
  always_comb begin
    prf_cfg_s k;
    k = PRF_CFG_RST;
    rl_w = '0;
    for (int r = 0; r < NR; r++) begin
      for (int c = 0; c < NC; c += PRF_TAP_STEP) begin
        k = cfg_r[r][c];
        // Large RAM positions do not break the wire
        if (k.rl_drv) begin
          rl_w[r][c / PRF_ROW_LONG_SPAN] =
            rl_w[r][c / PRF_ROW_LONG_SPAN] |
            pick(k.rl_src, blk_out_i[r][c], r4_arr[r][c],
                 ((r % PRF_TAP_STEP) == 0) ?
                   cl_w[r / PRF_COL_LONG_SPAN][c] : 1'b0,
                 c4_arr[r][c]);
        end
      end
    end
  end

  always_comb begin
    prf_cfg_s k;
    k = PRF_CFG_RST;
    cl_w = '0;
    for (int r = 0; r < NR; r += PRF_TAP_STEP) begin
      for (int c = 0; c < NC; c++) begin
        k = cfg_r[r][c];
        if (k.cl_drv) begin
          cl_w[r / PRF_COL_LONG_SPAN][c] =
            cl_w[r / PRF_COL_LONG_SPAN][c] |
            pick(k.cl_src, blk_out_i[r][c], c4_arr[r][c],
                 ((c % PRF_TAP_STEP) == 0) ?
                   rl_w[r][c / PRF_ROW_LONG_SPAN] : 1'b0,
                 r4_arr[r][c]);
        end
      end
    end
  end

  // ==========================================================
  // Local routing per block, long wires never enter directly
  always_comb begin
    prf_cfg_s k;
    logic lft;
    logic rgt;
    k = PRF_CFG_RST;
    lft = 1'b0;
    rgt = 1'b0;
    loc_o = '0;
    for (int r = 0; r < NR; r++) begin
      for (int c = 0; c < NC; c++) begin
        k = cfg_r[r][c];
        // A large RAM faces only its left neighbour
        lft = bit_at(blk_out_i, r, c - 1) & ~bit_at(big_m, r, c - 1);
        rgt = big_m[r][c] ? 1'b0 : bit_at(blk_out_i, r, c + 1);
        unique case (k.loc_sel)
          PRF_LOC_LEFT: loc_o[r][c] = lft;
          PRF_LOC_SELF: loc_o[r][c] = blk_out_i[r][c];
          PRF_LOC_RIGHT: loc_o[r][c] = rgt;
          PRF_LOC_ROW4: loc_o[r][c] = r4_arr[r][c];
          PRF_LOC_ROW8: loc_o[r][c] = r8_arr[r][c];
          PRF_LOC_COL4: loc_o[r][c] = c4_arr[r][c];
          PRF_LOC_COL8: loc_o[r][c] = c8_arr[r][c];
          PRF_LOC_NONE: loc_o[r][c] = 1'b0;
        endcase
        loc_o[r][c] = loc_o[r][c] & run_r;
      end
    end
  end

  // ==========================================================
  // Block clocks from the row clock lines
  always_comb begin
    for (int r = 0; r < NR; r++) begin
      for (int c = 0; c < NC; c++) begin
        blk_clk_o[r][c] = row_clk_i[r][cfg_r[r][c].clk_sel];
      end
    end
  end

  // ==========================================================
  // In-cluster chains
  for (genvar gr = 0; gr < NR; gr++) begin : g_row
    for (genvar gc = 0; gc < NC; gc++) begin : g_col
      prf_chain #(
        .CELLS(CELLS)
      ) u_chain (
        .en_i(run_r && cfg_r[gr][gc].kind == PRF_CLUSTER),
        .comb_i(cell_comb_i[gr][gc]),
        .regq_i(cell_regq_i[gr][gc]),
        .fast_o(fast_in_o[gr][gc]),
        .regd_o(reg_in_o[gr][gc])
      );
    end
  end

endmodule

/* shared/prf_pkg.sv */
// Constants and types for the programmable routing fabric
// ==========================================================
// Summary of operation
// - Blocks drive left, right and own local routing
// - Large RAM links on one side only
// - Row four-wire reaches four positions left/right
// - Each cluster owns directional row four-wires
// - Row four-wire driven by primary or neighbour
// - Row four-wires serve RAM, DSP, pin cells
// - Row four-wire drives four, column, long wires
// - Row eight-wire spans eight, drives eight-wires
// - Row long spans 24, taps every fourth
// - Row long drives long and four-wires
// - Row long crosses large RAM uninterrupted
// - Lookup chain feeds cell below, ten cells
// - Register chain links next cell register
// - Column four-wire spans four, any block
// - Column four-wire drives four and row wires
// - Column eight-wire spans eight, drives eight-wires
// - Column long spans 16, taps every fourth
// - Embedded blocks get wires, local, direct links
// - Blocks clocked from eight row clock lines
package prf_pkg;

  // ==========================================================
  // Geometry
  localparam int PRF_ROWS = 16;
  localparam int PRF_COLS = 24;
  localparam int PRF_CELLS = 10;
  localparam int PRF_CLK_LINES = 8;
  localparam int PRF_FOUR_SPAN = 4;
  localparam int PRF_EIGHT_SPAN = 8;
  localparam int PRF_ROW_LONG_SPAN = 24;
  localparam int PRF_COL_LONG_SPAN = 16;
  localparam int PRF_TAP_STEP = 4;

  // ==========================================================
  // Configuration types
  typedef enum logic [2:0] {
    PRF_CLUSTER,
    PRF_SMALL_RAM,
    PRF_MID_RAM,
    PRF_BIG_RAM,
    PRF_DSP,
    PRF_PIN
  } prf_kind_e;

  typedef enum logic [1:0] {
    PRF_SRC_BLOCK,
    PRF_SRC_SAME,
    PRF_SRC_CROSS,
    PRF_SRC_LONG
  } prf_src_e;

  typedef enum logic [2:0] {
    PRF_LOC_LEFT,
    PRF_LOC_SELF,
    PRF_LOC_RIGHT,
    PRF_LOC_ROW4,
    PRF_LOC_ROW8,
    PRF_LOC_COL4,
    PRF_LOC_COL8,
    PRF_LOC_NONE
  } prf_loc_e;

  typedef struct packed {
    prf_kind_e kind;
    prf_loc_e loc_sel;
    logic r4_en;
    logic r4_fwd;
    logic r4_nbr;
    prf_src_e r4_src;
    logic r8_en;
    logic r8_fwd;
    logic r8_nbr;
    prf_src_e r8_src;
    logic c4_en;
    logic c4_fwd;
    logic c4_nbr;
    prf_src_e c4_src;
    logic c8_en;
    logic c8_fwd;
    logic c8_nbr;
    prf_src_e c8_src;
    logic rl_drv;
    prf_src_e rl_src;
    logic cl_drv;
    prf_src_e cl_src;
    logic [2:0] clk_sel;
  } prf_cfg_s;

  localparam int PRF_CFG_W = $bits(prf_cfg_s);
  localparam prf_cfg_s PRF_CFG_RST = '0;
  localparam logic PRF_RUN_RST = 1'b0;

endpackage

/* verif/prf_blocks.sv */
// Model of the blocks and clock lines around the fabric
`timescale 1ns/100ps
module prf_blocks
  import prf_pkg::*;
(
  input wire logic clk_i,
  input wire logic [PRF_ROWS-1:0][PRF_COLS-1:0] pat_i,
  input wire logic [PRF_CELLS-1:0] seed_i,
  output logic [PRF_ROWS-1:0][PRF_COLS-1:0] blk_out_o,
  output logic [PRF_ROWS-1:0][PRF_CLK_LINES-1:0] row_clk_o,
  output logic [PRF_ROWS-1:0][PRF_COLS-1:0][PRF_CELLS-1:0] comb_o,
  output logic [PRF_ROWS-1:0][PRF_COLS-1:0][PRF_CELLS-1:0] regq_o
);
  // ====
  // Row clock lines at binary rates
  logic [PRF_CLK_LINES-1:0] div_r = 8'h00;
  always_ff @(posedge clk_i) begin
    div_r <= div_r + 8'h01;
  end
  always_comb begin
    blk_out_o = pat_i;
    for (int r = 0; r < PRF_ROWS; r++) begin
      row_clk_o[r] = div_r;
      for (int c = 0; c < PRF_COLS; c++) begin
        comb_o[r][c] = seed_i ^ {PRF_CELLS{pat_i[r][c]}};
        regq_o[r][c] = ~seed_i;
      end
    end
  end
endmodule

/* verif/prf_fabric_test.sv */
// Self-checking bench for the routing fabric
`timescale 1ns/100ps
module prf_fabric_test
  import prf_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic we = 1'b0;
  logic [3:0] row = 4'h0;
  logic [4:0] col = 5'h00;
  prf_cfg_s word = '0;
  prf_cfg_s w;
  logic [PRF_ROWS-1:0][PRF_COLS-1:0] pat = '0;
  logic [PRF_CELLS-1:0] seed = 10'h000;
  logic [PRF_ROWS-1:0][PRF_COLS-1:0] blk_out, loc, bclk;
  logic [PRF_ROWS-1:0][PRF_CLK_LINES-1:0] row_clk;
  logic [PRF_ROWS-1:0][PRF_COLS-1:0][PRF_CELLS-1:0] comb, regq, fast, regin;
  logic run_out;
  int n_errors = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  prf_blocks blocks (.clk_i(clk), .pat_i(pat), .seed_i(seed),
    .blk_out_o(blk_out), .row_clk_o(row_clk), .comb_o(comb), .regq_o(regq));
  prf_fabric uut (.clk_i(clk), .reset_i(reset), .run_i(run),
    .cfg_we_i(we), .cfg_row_i(row), .cfg_col_i(col), .cfg_word_i(word),
    .blk_out_i(blk_out), .row_clk_i(row_clk), .cell_comb_i(comb),
    .cell_regq_i(regq), .run_o(run_out), .loc_o(loc), .blk_clk_o(bclk),
    .fast_in_o(fast), .reg_in_o(regin));
  // ====
  // Shared tasks
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input int n);
    reset = 1'b1;
    run = 1'b0;
    we = 1'b0;
    pat = '0;
    repeat (n) step();
    reset = 1'b0;
  endtask
  task automatic put(input int r, input int c, input prf_cfg_s v);
    we = 1'b1;
    row = 4'(r);
    col = 5'(c);
    word = v;
    step();
  endtask
  task automatic go(input logic v);
    we = 1'b0;
    run = v;
    step();
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_reset();
    do_reset(1);
    check(run_out, 1'b0);
    check(|loc, 1'b0);
    check(bclk[7][3], row_clk[7][0]);
    $display("done reset");
  endtask
  task automatic t_direct();
    for (int k = 0; k < 3; k++) begin
      do_reset(1);
      w = '0;
      w.loc_sel = prf_loc_e'(k);
      put(2, 5, w);
      go(1'b1);
      pat[2][4+k] = 1'b1;
      step();
      check(loc[2][5], 1'b1);
      pat = '0;
      pat[2][4+(k+1)%3] = 1'b1;
      step();
      check(loc[2][5], 1'b0);
    end
    $display("done direct");
  endtask
  task automatic t_row4();
    do_reset(1);
    w = '0;
    w.r4_en = 1'b1;
    w.r4_fwd = 1'b1;
    put(3, 4, w);
    w.r4_src = PRF_SRC_SAME;
    w.loc_sel = PRF_LOC_ROW4;
    put(3, 8, w);
    w = '0;
    w.loc_sel = PRF_LOC_ROW4;
    put(3, 12, w);
    go(1'b1);
    pat[3][4] = 1'b1;
    step();
    check(loc[3][8], 1'b1);
    check(loc[3][12], 1'b1);
    pat = '0;
    pat[3][5] = 1'b1;
    step();
    check(loc[3][8], 1'b0);
    go(1'b0);
    w = '0;
    w.kind = PRF_DSP;
    w.r4_en = 1'b1;
    w.r4_fwd = 1'b1;
    w.r4_nbr = 1'b1;
    put(3, 4, w);
    go(1'b1);
    check(loc[3][8], 1'b1);
    pat = '0;
    pat[3][3] = 1'b1;
    step();
    check(loc[3][8], 1'b0);
    $display("done row four");
  endtask
  task automatic t_cross();
    do_reset(1);
    w = '0;
    w.r8_en = 1'b1;
    w.r8_fwd = 1'b1;
    put(5, 2, w);
    w = '0;
    w.loc_sel = PRF_LOC_ROW8;
    w.c8_en = 1'b1;
    w.c8_src = PRF_SRC_CROSS;
    put(5, 10, w);
    w = '0;
    w.loc_sel = PRF_LOC_COL8;
    put(13, 10, w);
    w = '0;
    w.c4_en = 1'b1;
    w.c4_fwd = 1'b1;
    w.c4_nbr = 1'b1;
    put(8, 3, w);
    w = '0;
    w.loc_sel = PRF_LOC_COL4;
    w.r4_en = 1'b1;
    w.r4_fwd = 1'b1;
    w.r4_src = PRF_SRC_CROSS;
    put(4, 3, w);
    w = '0;
    w.loc_sel = PRF_LOC_ROW4;
    put(4, 7, w);
    go(1'b1);
    pat[5][2] = 1'b1;
    pat[8][4] = 1'b1;
    step();
    check(loc[5][10], 1'b1);
    check(loc[13][10], 1'b1);
    check(loc[4][3], 1'b1);
    check(loc[4][7], 1'b1);
    pat = '0;
    pat[8][3] = 1'b1;
    step();
    check(loc[4][3], 1'b0);
    $display("done cross wires");
  endtask
  task automatic t_long();
    do_reset(1);
    w = '0;
    w.rl_drv = 1'b1;
    put(6, 0, w);
    w = '0;
    w.kind = PRF_BIG_RAM;
    put(6, 8, w);
    w = '0;
    w.r4_en = 1'b1;
    w.r4_src = PRF_SRC_LONG;
    put(6, 20, w);
    put(6, 21, w);
    w = '0;
    w.c4_en = 1'b1;
    w.c4_src = PRF_SRC_LONG;
    put(8, 5, w);
    put(9, 5, w);
    w = '0;
    w.cl_drv = 1'b1;
    put(0, 5, w);
    w = '0;
    w.loc_sel = PRF_LOC_ROW4;
    put(6, 16, w);
    put(6, 17, w);
    w.loc_sel = PRF_LOC_COL4;
    put(12, 5, w);
    put(13, 5, w);
    go(1'b1);
    pat[6][0] = 1'b1;
    pat[0][5] = 1'b1;
    step();
    check(loc[6][16], 1'b1);
    check(loc[6][17], 1'b0);
    check(loc[12][5], 1'b1);
    check(loc[13][5], 1'b0);
    $display("done long wires");
  endtask
  task automatic t_bigram();
    do_reset(1);
    w = '0;
    w.kind = PRF_BIG_RAM;
    w.loc_sel = PRF_LOC_RIGHT;
    put(1, 6, w);
    go(1'b1);
    pat[1][7] = 1'b1;
    step();
    check(loc[1][6], 1'b0);
    go(1'b0);
    w.loc_sel = PRF_LOC_LEFT;
    put(1, 6, w);
    go(1'b1);
    pat = '0;
    pat[1][5] = 1'b1;
    step();
    check(loc[1][6], 1'b1);
    $display("done large ram");
  endtask
  task automatic t_chain();
    do_reset(1);
    go(1'b1);
    seed = 10'h2B5;
    pat[4][9] = 1'b1;
    step();
    check(fast[4][9], {~seed[8:0], 1'b0});
    check(regin[4][9], {~seed[8:0], 1'b0});
    go(1'b0);
    w = '0;
    w.kind = PRF_DSP;
    put(4, 9, w);
    go(1'b1);
    check(fast[4][9], 10'h000);
    $display("done chains");
  endtask
  task automatic t_clock();
    do_reset(1);
    w = '0;
    for (int k = 0; k < PRF_CLK_LINES; k++) begin
      w.clk_sel = 3'(k);
      put(0, 3, w);
      go(1'b0);
      repeat (2) begin
        step();
        check(bclk[0][3], row_clk[0][k]);
      end
    end
    $display("done clocks");
  endtask
  task automatic t_frozen();
    do_reset(1);
    w = '0;
    w.loc_sel = PRF_LOC_SELF;
    put(2, 2, w);
    go(1'b1);
    check(run_out, 1'b1);
    w.loc_sel = PRF_LOC_NONE;
    put(2, 2, w);
    go(1'b1);
    pat[2][2] = 1'b1;
    step();
    check(loc[2][2], 1'b1);
    $display("done frozen");
  endtask
  initial begin
    do_reset(6);
    t_reset();
    t_direct();
    t_row4();
    t_cross();
    t_long();
    t_bigram();
    t_chain();
    t_clock();
    t_frozen();
    finish_test();
  end
endmodule

/* verif/prf_props.sv */
// Port checker for the routing fabric
`timescale 1ns/100ps
module prf_props
  import prf_pkg::*;
#(
  parameter int NR = PRF_ROWS,
  parameter int NC = PRF_COLS,
  parameter int CELLS = PRF_CELLS
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic cfg_we_i,
  input wire logic [NR-1:0][NC-1:0] blk_out_i,
  input wire logic [NR-1:0][PRF_CLK_LINES-1:0] row_clk_i,
  input wire logic [NR-1:0][NC-1:0][CELLS-1:0] cell_comb_i,
  input wire logic [NR-1:0][NC-1:0][CELLS-1:0] cell_regq_i,
  input wire logic run_o,
  input wire logic [NR-1:0][NC-1:0] loc_o,
  input wire logic [NR-1:0][NC-1:0] blk_clk_o,
  input wire logic [NR-1:0][NC-1:0][CELLS-1:0] fast_in_o,
  input wire logic [NR-1:0][NC-1:0][CELLS-1:0] reg_in_o
);
  // ====
  // Helper views
  logic [NR-1:0][NC-1:0][CELLS-1:0] lut_up;
  logic [NR-1:0][NC-1:0][CELLS-1:0] reg_up;
  logic [NR-1:0][NC-1:0] clk0;
  logic clk_bad;
  always_comb begin
    clk_bad = 1'b0;
    for (int r = 0; r < NR; r++) begin
      for (int c = 0; c < NC; c++) begin
        lut_up[r][c] = {cell_comb_i[r][c][CELLS-2:0], 1'b0};
        reg_up[r][c] = {cell_regq_i[r][c][CELLS-2:0], 1'b0};
        clk0[r][c] = row_clk_i[r][0];
        clk_bad |= &row_clk_i[r] & ~blk_clk_o[r][c];
        clk_bad |= ~|row_clk_i[r] & blk_clk_o[r][c];
      end
    end
  end
  // ====
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_left_reset;
    $past(reset_i);
  endsequence
  sequence s_quiet;
    $stable(blk_out_i) && $stable(cell_comb_i) && $stable(cell_regq_i)
      && $stable(run_o) && !$past(cfg_we_i) && !$past(reset_i);
  endsequence
  a_reset_idle: assert property (
    s_left_reset |-> !run_o && blk_clk_o == clk0)
    else $error("fabric not idle after reset");
  a_run_follow: assert property (
    !$past(reset_i) |-> run_o == $past(run_i))
    else $error("run state does not follow request");
  a_loc_idle: assert property (!run_o |-> loc_o == '0)
    else $error("local routing live while stopped");
  a_chain_idle: assert property (
    !run_o |-> fast_in_o == '0 && reg_in_o == '0)
    else $error("chains live while stopped");
  a_lut_chain: assert property ((fast_in_o & ~lut_up) == '0)
    else $error("fast input not from cell above");
  a_reg_chain: assert property ((reg_in_o & ~reg_up) == '0)
    else $error("register input not from previous cell");
  a_clk_source: assert property (!clk_bad)
    else $error("block clock not from its row lines");
  a_no_state: assert property (
    s_quiet |-> $stable(loc_o) && $stable(fast_in_o))
    else $error("routing output changed with quiet inputs");
endmodule

bind prf_fabric prf_props #(.NR(NR), .NC(NC), .CELLS(CELLS)) u_props (
  .clk_i, .reset_i, .run_i, .cfg_we_i, .blk_out_i, .row_clk_i,
  .cell_comb_i, .cell_regq_i, .run_o, .loc_o, .blk_clk_o, .fast_in_o,
  .reg_in_o
);
